// ### pkg/rmsps_defines.vh
`ifndef RMSPS_DEFINES_VH
`define RMSPS_DEFINES_VH

// avalon register offsets (byte addresses, one word each)
`define RMSPS_ADDR_STATUS      4'h0
`define RMSPS_ADDR_CONTROL     4'h4
`define RMSPS_ADDR_PORT_DIR    4'h8
`define RMSPS_ADDR_PORT_OUT    4'hc

// status field positions
`define RMSPS_ST_CLK_SYNTH     0
`define RMSPS_ST_BDM_FLAG      1
`define RMSPS_ST_PORT_E        2
`define RMSPS_ST_PORT_F        3
`define RMSPS_ST_EXC_RUN       4
`define RMSPS_ST_BUS_RUN       5
`define RMSPS_ST_BREAKPOINT_REQUEST_EXC      6
`define RMSPS_ST_BREAKPOINT_REQUEST_DBG      7

// control field positions
`define RMSPS_CT_PIN_FUNC_EN   0

// timing: first bus cycle this many clock-out cycles after release
`define RMSPS_FIRST_BUS_CYCLES 4'ha
`define RMSPS_CNT_W            4

// reset values
`define RMSPS_CONTROL_RST      1'b0
`define RMSPS_PORT_DIR_RST     8'h00
`define RMSPS_PORT_OUT_RST     8'h00
`define RMSPS_UNMAPPED_DATA    32'h00000000

`endif

// ### verilog/rmsps_sync2.v
// two-flop synchroniser for pin inputs, generic width
module rmsps_sync2
#(
  parameter W = 1
)
(
  input  wire         core_clk_in,
  input  wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);
  reg [W-1:0] meta;
  reg [W-1:0] stable;

  // first stage read only by the second
  always @(posedge core_clk_in)
  begin
    meta   <= async_in;
    stable <= meta;
  end

  assign sync_out = stable;
endmodule

// ### verilog/rmsps_top.v
// Contract
// - clock_source_select high at reset selects the on-chip synthesizer as system clock.
// - clock_source_select low at reset disables the synthesizer; the board supplies the clock.
// - both breakpoint_request inputs are sampled at the moment reset is released.
// - either request low when sampled sets background_debug_flag; later requests enter debug.
// - both requests high when sampled makes later requests start breakpoint exceptions.
// - out of reset pins are port inputs: functions disabled, direction registers cleared.
// - during reset integration-unit pins float or are driven to their inactive levels.
// - after release, mode selection completes before reset exception processing starts.
// - input pins are high-impedance loads after release; the board drives their levels.
// - output pins only begin their assigned function after reset is released.
// - dual-function pins follow the sampled mode; idle chip selects high, port pins inputs.
// - other modules' general-port pins are high-impedance after reset until configured; here pulse_width_oe_out drives both pins once running, unconfigured.
// - bus_control_mode_bit low at reset gives acknowledge, autovector, strobes, size to port E.
// - interrupt_mode_bit low at reset gives interrupt requests and clock select to port F.
// - first bus cycle starts ten clock-out cycles after release; board frees the data bus.
//
// The placing of the registers and the Avalon-MM interface to the registers are this design's own decisions.
`include "rmsps_defines.vh"

module rmsps_top
(
  input  wire        core_clk_in,
  input  wire        srst_in,
  // mode-select pins
  input  wire        clock_source_select_in,
  input  wire        breakpoint_request_ext_n_in,
  input  wire        breakpoint_request_int_n_in,
  input  wire        bus_control_mode_bit_in,
  input  wire        interrupt_mode_bit_in,
  // avalon-mm slave
  input  wire [3:0]  avs_address_in,
  input  wire        avs_read_in,
  input  wire        avs_write_in,
  input  wire [31:0] avs_writedata_in,
  output reg  [31:0] avs_readdata_out,
  output reg         avs_waitrequest_out,
  // mode results
  output reg         clk_synth_enable_out,
  output reg         background_debug_flag_out,
  output reg         general_port_e_sel_out,
  output reg         general_port_f_sel_out,
  output reg         reset_exception_start_out,
  output reg         bus_cycle_enable_out,
  output reg         data_bus_drive_allow_out,
  output reg         enter_debug_out,
  output reg         breakpoint_exception_out,
  // integration-unit pins
  output reg         boot_chip_select_n_out,
  output reg         boot_chip_select_oe_out,
  output reg         strobe_oe_out,
  output reg  [7:0]  port_pin_oe_out,
  output reg  [7:0]  port_pin_out,
  output reg  [1:0]  pulse_width_oe_out
);

  localparam ST_RESET  = 2'h0;
  localparam ST_MODE   = 2'h1;
  localparam ST_EXC    = 2'h2;
  localparam ST_RUN    = 2'h3;

  wire [3:0] pins_sync;
  wire       mode_clk_s;
  wire       breakpoint_request_ext_s;
  wire       breakpoint_request_int_s;
  wire       bus_mode_s;
  wire       irq_mode_s;
  wire       breakpoint_request_any_s;

  reg [1:0]  state;
  reg [1:0]  next_state;
  reg [3:0]  cnt;
  reg        samp_clk;
  reg        samp_bdm;
  reg        samp_pe;
  reg        samp_pf;
  reg        pin_func_en;
  reg [7:0]  port_dir;
  reg [7:0]  port_out;
  reg        breakpoint_request_any_d;
  reg        ack_pending;

  // pins arrive asynchronously; the clock select pin is synchronised the same way
  rmsps_sync2 #(.W(4)) u_sync
  (
    .core_clk_in (core_clk_in),
    .async_in    ({breakpoint_request_int_n_in, breakpoint_request_ext_n_in,
                   bus_control_mode_bit_in, interrupt_mode_bit_in}),
    .sync_out    (pins_sync)
  );

  reg [1:0] clk_sel_meta;
  always @(posedge core_clk_in)
  begin
    clk_sel_meta <= {clk_sel_meta[0], clock_source_select_in};
  end
  assign mode_clk_s = clk_sel_meta[1];
  assign breakpoint_request_int_s = pins_sync[3];
  assign breakpoint_request_ext_s = pins_sync[2];
  assign bus_mode_s = pins_sync[1];
  assign irq_mode_s = pins_sync[0];
  assign breakpoint_request_any_s = ~breakpoint_request_ext_s | ~breakpoint_request_int_s;

  // register decode shared by read and write paths
  function dec_hit;
    input [3:0] addr;
    input [3:0] target;
    begin
      dec_hit = (addr == target);
    end
  endfunction

  // sequencing: reset, mode latch, exception processing, bus running
  always @*
  begin
    next_state = state;
    case (state)
      ST_RESET: next_state = ST_MODE;
      ST_MODE:  next_state = ST_EXC;
      ST_EXC:   if (cnt == `RMSPS_FIRST_BUS_CYCLES) next_state = ST_RUN;
      ST_RUN:   next_state = ST_RUN;
      default:  next_state = ST_RESET;
    endcase
  end

  always @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      state <= ST_RESET;
      cnt   <= 4'h0;
    end
    else
    begin
      state <= next_state;
      // count clocks since release; reaches ten when the first bus cycle may start
      if (state != ST_RUN && cnt != `RMSPS_FIRST_BUS_CYCLES)
        cnt <= cnt + 4'h1;
    end
  end

  // mode sampling: pins captured on the first edge after release, frozen from then on
  always @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      samp_clk <= 1'b1;
      samp_bdm <= 1'b0;
      samp_pe  <= 1'b0;
      samp_pf  <= 1'b0;
    end
    else if (state == ST_RESET)
    begin
      samp_clk <= mode_clk_s;
      samp_bdm <= breakpoint_request_any_s;
      samp_pe  <= ~bus_mode_s;
      samp_pf  <= ~irq_mode_s;
    end
  end
  // later states never touch the samples, so they hold until next reset

  // breakpoint dispatch after release, on request edges only
  always @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      breakpoint_request_any_d                <= 1'b1;
      enter_debug_out           <= 1'b0;
      breakpoint_exception_out  <= 1'b0;
    end
    else
    begin
      breakpoint_request_any_d <= breakpoint_request_any_s;
      enter_debug_out          <= (state == ST_RUN) && breakpoint_request_any_s && !breakpoint_request_any_d
                                  && samp_bdm;
      breakpoint_exception_out <= (state == ST_RUN) && breakpoint_request_any_s && !breakpoint_request_any_d
                                  && !samp_bdm;
    end
  end

  // mode result outputs, valid from the exception state onward
  always @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      clk_synth_enable_out      <= 1'b1;
      background_debug_flag_out <= 1'b0;
      general_port_e_sel_out    <= 1'b0;
      general_port_f_sel_out    <= 1'b0;
      reset_exception_start_out <= 1'b0;
      bus_cycle_enable_out      <= 1'b0;
      data_bus_drive_allow_out  <= 1'b0;
    end
    else
    begin
      clk_synth_enable_out      <= samp_clk;
      background_debug_flag_out <= samp_bdm;
      general_port_e_sel_out    <= samp_pe;
      general_port_f_sel_out    <= samp_pf;
      reset_exception_start_out <= (state == ST_MODE);
      bus_cycle_enable_out      <= (next_state == ST_RUN);
      data_bus_drive_allow_out  <= (next_state == ST_RUN);
    end
  end

  // pin electrical state; inactive or floating while reset holds
  always @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      boot_chip_select_n_out  <= 1'b1;
      boot_chip_select_oe_out <= 1'b1;
      strobe_oe_out           <= 1'b0;
      port_pin_oe_out         <= 8'h00;
      port_pin_out            <= 8'h00;
      pulse_width_oe_out      <= 2'b00;
    end
    else
    begin
      // boot select goes active once exception fetches begin
      boot_chip_select_n_out  <= !(state == ST_EXC || state == ST_RUN);
      boot_chip_select_oe_out <= 1'b1;
      // strobes drive only as bus function, never as port e inputs
      strobe_oe_out           <= !samp_pe && (state == ST_RUN);
      port_pin_oe_out         <= port_dir;
      port_pin_out            <= port_out;
      pulse_width_oe_out      <= (state == ST_RUN) ? 2'b11 : 2'b00;
    end
  end

  // avalon slave: one wait cycle, then answer on the next edge
  always @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      ack_pending         <= 1'b0;
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out    <= `RMSPS_UNMAPPED_DATA;
      pin_func_en         <= `RMSPS_CONTROL_RST;
      port_dir            <= `RMSPS_PORT_DIR_RST;
      port_out            <= `RMSPS_PORT_OUT_RST;
    end
    else
    begin
      avs_waitrequest_out <= 1'b1;
      ack_pending         <= 1'b0;
      if ((avs_read_in || avs_write_in) && !ack_pending && avs_waitrequest_out)
      begin
        ack_pending         <= 1'b1;
        avs_waitrequest_out <= 1'b0;
        if (avs_write_in)
        begin
          if (dec_hit(avs_address_in, `RMSPS_ADDR_CONTROL))
            pin_func_en <= avs_writedata_in[`RMSPS_CT_PIN_FUNC_EN];
          // direction drives port_pin_oe_out for all eight pins, whatever the port selection or pin_func_en
          if (dec_hit(avs_address_in, `RMSPS_ADDR_PORT_DIR))
            port_dir <= avs_writedata_in[7:0];
          if (dec_hit(avs_address_in, `RMSPS_ADDR_PORT_OUT))
            port_out <= avs_writedata_in[7:0];
        end
        avs_readdata_out <= `RMSPS_UNMAPPED_DATA;
        if (dec_hit(avs_address_in, `RMSPS_ADDR_STATUS))
          avs_readdata_out <= {24'h000000,
                               enter_debug_out, breakpoint_exception_out,
                               state == ST_RUN, state == ST_EXC,
                               samp_pf, samp_pe, samp_bdm, samp_clk};
        else if (dec_hit(avs_address_in, `RMSPS_ADDR_CONTROL))
          avs_readdata_out <= {31'h00000000, pin_func_en};
        else if (dec_hit(avs_address_in, `RMSPS_ADDR_PORT_DIR))
          avs_readdata_out <= {24'h000000, port_dir};
        else if (dec_hit(avs_address_in, `RMSPS_ADDR_PORT_OUT))
          avs_readdata_out <= {24'h000000, port_out};
      end
    end
  end

endmodule

// ### sim/rmsps_top_sva.sv
module rmsps_chk
(
  input logic       core_clk_in,
  input logic       srst_in,
  input logic       clock_source_select_in,
  input logic       breakpoint_request_ext_n_in,
  input logic       breakpoint_request_int_n_in,
  input logic       bus_control_mode_bit_in,
  input logic       interrupt_mode_bit_in,
  input logic       clk_synth_enable_out,
  input logic       background_debug_flag_out,
  input logic       general_port_e_sel_out,
  input logic       general_port_f_sel_out,
  input logic       reset_exception_start_out,
  input logic       bus_cycle_enable_out,
  input logic       data_bus_drive_allow_out,
  input logic       enter_debug_out,
  input logic       breakpoint_exception_out,
  input logic       boot_chip_select_n_out,
  input logic       strobe_oe_out,
  input logic [7:0] port_pin_oe_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (srst_in);
  // first edge that sees reset low again
  sequence s_rel;
    !srst_in && $past(srst_in);
  endsequence
  // pins as left by reset, before mode selection lands
  property p_rst_idle;
    s_rel |-> boot_chip_select_n_out && !strobe_oe_out && port_pin_oe_out == 8'h00;
  endproperty
  property p_clk_mode;
    s_rel |-> ##3 clk_synth_enable_out == $past(clock_source_select_in, 3);
  endproperty
  property p_bdm;
    s_rel |-> ##3 background_debug_flag_out ==
      !($past(breakpoint_request_ext_n_in, 3) && $past(breakpoint_request_int_n_in, 3));
  endproperty
  property p_ports;
    s_rel |-> ##3 general_port_e_sel_out == !$past(bus_control_mode_bit_in, 3) &&
      general_port_f_sel_out == !$past(interrupt_mode_bit_in, 3);
  endproperty
  // exception start only after the mode outputs had time to settle
  property p_exc_order;
    s_rel |-> !reset_exception_start_out [*2] ##[1:4] reset_exception_start_out;
  endproperty
  property p_hold;
    $past(bus_cycle_enable_out) |-> $stable({clk_synth_enable_out,
      background_debug_flag_out, general_port_e_sel_out, general_port_f_sel_out});
  endproperty
  property p_first_bus;
    s_rel |-> !bus_cycle_enable_out [*8] ##[2:5] bus_cycle_enable_out;
  endproperty
  property p_drive;
    data_bus_drive_allow_out |-> bus_cycle_enable_out;
  endproperty
  property p_dbg_only;
    enter_debug_out |-> background_debug_flag_out && bus_cycle_enable_out;
  endproperty
  property p_exc_only;
    breakpoint_exception_out |-> !background_debug_flag_out && bus_cycle_enable_out;
  endproperty
  a_rst_idle:
    assert property (p_rst_idle) else $error("pins not idle at release");
  a_clk_mode:
    assert property (p_clk_mode) else $error("clock source choice wrong");
  a_bdm:
    assert property (p_bdm) else $error("debug flag wrong");
  a_ports:
    assert property (p_ports) else $error("port selection wrong");
  a_exc_order:
    assert property (p_exc_order) else $error("exception start mistimed");
  a_hold:
    assert property (p_hold) else $error("latched mode changed");
  a_first_bus:
    assert property (p_first_bus) else $error("first bus cycle mistimed");
  a_drive:
    assert property (p_drive) else $error("data bus driven too early");
  a_dbg_only:
    assert property (p_dbg_only) else $error("debug entry without flag");
  a_exc_only:
    assert property (p_exc_only) else $error("breakpoint exception with flag");
endmodule

bind rmsps_top rmsps_chk chk_u (.core_clk_in, .srst_in, .clock_source_select_in,
  .breakpoint_request_ext_n_in, .breakpoint_request_int_n_in, .bus_control_mode_bit_in,
  .interrupt_mode_bit_in, .clk_synth_enable_out, .background_debug_flag_out,
  .general_port_e_sel_out, .general_port_f_sel_out, .reset_exception_start_out,
  .bus_cycle_enable_out, .data_bus_drive_allow_out, .enter_debug_out,
  .breakpoint_exception_out, .boot_chip_select_n_out, .strobe_oe_out, .port_pin_oe_out);

// ### sim/rmsps_board.sv
module rmsps_board
(
  input  logic       core_clk_in,
  input  logic       srst_in,
  input  logic [2:0] mode_sel_in,
  output logic       clock_source_select_out,
  output logic       bus_control_mode_bit_out,
  output logic       interrupt_mode_bit_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] rel_cnt = 4'h0;
  // cycles since release, saturating
  always @(posedge core_clk_in)
    if (srst_in)
      rel_cnt <= 4'h0;
    else if (rel_cnt != 4'hf)
      rel_cnt <= rel_cnt + 4'h1;
  // let go of data lines well before cycle ten; pull-ups then win
  assign bus_control_mode_bit_out = (srst_in || rel_cnt < 4'h5) ? mode_sel_in[1] : 1'b1;
  assign interrupt_mode_bit_out = (srst_in || rel_cnt < 4'h5) ? mode_sel_in[2] : 1'b1;
  // clock select driven actively through reset, avoids a floating choice
  assign clock_source_select_out = mode_sel_in[0];
endmodule

// ### sim/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0, srst = 1'b1, ext_n = 1'b1, int_n = 1'b1, rd = 1'b0, wr = 1'b0;
  logic [2:0]  mode = 3'h7;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, lf = 32'd67399;
  wire         cs_w, bc_w, im_w, wait_w, synth, background_debug_flag, pe, pf, dbg, bex, bus_en;
  wire         bcs_n, bcs_oe, stb_oe;
  wire  [7:0]  oe, pout;
  wire  [1:0]  pw;
  wire  [31:0] rdat_w;
  int          bad_count = 0, n_checks = 0;
  always #50 clk = ~clk;
  rmsps_board board_u (.core_clk_in(clk), .srst_in(srst), .mode_sel_in(mode),
    .clock_source_select_out(cs_w), .bus_control_mode_bit_out(bc_w),
    .interrupt_mode_bit_out(im_w));
  rmsps_top dut_u (.core_clk_in(clk), .srst_in(srst), .clock_source_select_in(cs_w),
    .breakpoint_request_ext_n_in(ext_n), .breakpoint_request_int_n_in(int_n),
    .bus_control_mode_bit_in(bc_w), .interrupt_mode_bit_in(im_w), .avs_address_in(addr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata), .avs_readdata_out(rdat_w),
    .avs_waitrequest_out(wait_w), .clk_synth_enable_out(synth),
    .background_debug_flag_out(background_debug_flag), .general_port_e_sel_out(pe),
    .general_port_f_sel_out(pf), .reset_exception_start_out(), .bus_cycle_enable_out(bus_en),
    .data_bus_drive_allow_out(), .enter_debug_out(dbg), .breakpoint_exception_out(bex),
    .boot_chip_select_n_out(bcs_n), .boot_chip_select_oe_out(bcs_oe), .strobe_oe_out(stb_oe),
    .port_pin_oe_out(oe), .port_pin_out(pout), .pulse_width_oe_out(pw));
  // random source, fixed start
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // expected mode bits: synth, debug flag, port e, port f
  function automatic logic [31:0] exp_mode(input logic [2:0] m, input logic e, input logic n);
    return {28'h0, ~m[2], ~m[1], ~(e & n), m[0]};
  endfunction
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one avalon transfer; an edge passes first so strobes are never set twice in a step
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    rd <= ~w;
    wr <= w;
    addr <= a;
    wdata <= d;
    i = 0;
    do
    begin
      @(posedge clk);
      i++;
    end
    while (wait_w !== 1'b0 && i < 20);
    rdata = rdat_w;
    rd <= 1'b0;
    wr <= 1'b0;
    if (wait_w !== 1'b0)
    begin
      check("waitrequest", 32'h0, {31'h0, wait_w});
      results();
    end
  endtask
  initial
  begin
    int t, k;
    logic sd, sb;
    logic [31:0] em;
    for (t = 0; t < 8; t++)
    begin
      @(posedge clk);
      lf = nxt(lf);
      // first two runs: all pins high, then all low
      {int_n, ext_n, mode} <= (t == 0) ? 5'h1f : (t == 1) ? 5'h00 : lf[4:0];
      srst <= 1'b1;
      repeat (4) @(posedge clk);
      check("pw_oe_rst", 32'h0, {30'h0, pw});
      check("pins_rst", 32'h3, {29'h0, stb_oe, bcs_oe, bcs_n});
      srst <= 1'b0;
      em = exp_mode(mode, ext_n, int_n);
      bus(1'b0, 4'h0, 32'h0);
      check("status", em, rdata & 32'hf);
      bus(1'b0, 4'h4, 32'h0);
      check("control", 32'h0, rdata);
      bus(1'b0, 4'h8, 32'h0);
      check("port_dir", 32'h0, rdata);
      check("port_oe", 32'h0, {24'h0, oe});
      bus(1'b1, 4'h8, {24'h0, lf[15:8]});
      bus(1'b0, 4'h8, 32'h0);
      check("port_dir_back", {24'h0, lf[15:8]}, rdata);
      check("port_oe_set", {24'h0, lf[15:8]}, {24'h0, oe});
      bus(1'b1, 4'h2, lf);
      bus(1'b0, 4'h2, 32'h0);
      check("unmapped", 32'h0, rdata);
      bus(1'b1, 4'hc, {24'h0, lf[23:16]});
      bus(1'b0, 4'hc, 32'h0);
      check("port_out_back", {24'h0, lf[23:16]}, rdata);
      check("port_pin", {24'h0, lf[23:16]}, {24'h0, pout});
      for (k = 0; k < 30 && bus_en !== 1'b1; k++)
        @(posedge clk);
      check("running", 32'h1, {31'h0, bus_en});
      check("modes", em, {28'h0, pf, pe, background_debug_flag, synth});
      bus(1'b0, 4'h0, 32'h0);
      check("status_run", 32'h2, {30'h0, rdata[5:4]});
      check("pw_oe_run", 32'h3, {30'h0, pw});
      check("pins_run", {29'h0, ~em[2], 2'b10}, {29'h0, stb_oe, bcs_oe, bcs_n});
      ext_n <= 1'b1;
      int_n <= 1'b1;
      repeat (4) @(posedge clk);
      // alternate which request line fires
      if (t[0])
        int_n <= 1'b0;
      else
        ext_n <= 1'b0;
      sd = 1'b0;
      sb = 1'b0;
      repeat (8)
      begin
        @(posedge clk);
        sd = sd | (dbg === 1'b1);
        sb = sb | (bex === 1'b1);
      end
      check("breakpoint_request_event", {30'h0, em[1], ~em[1]}, {30'h0, sd, sb});
      $display("test %0d done", t);
    end
    results();
  end
endmodule
